// file: src/pmc_power_mgmt.v
`timescale 1ns/1ps
// Summary of operation
// - Capability at cfg 42h/local 182h, control at cfg 44h/local 184h
// - Version bits 2:0 reset 001, read both sides, written locally only
// - Bit 3 clock-needed flag, local write only, resets 0
// - Bit 5 special-init flag, local write only, resets 0
// - Auxiliary current bits 8:6 read-only zero
// - Bits 9 and 10 advertise D1 and State2_supported, local write
// - Bits 15:11 wake-capable state flags, local write, reset zero
// - Power state bits 1:0 writable both sides, reset D0
// - D3hot to D0 change pulses a soft reset including local interface
// - In D3hot refuse memory, I/O and interrupts; configuration only
// - D2 with State2_supported refuses traffic like D3hot; leaving it pulses no soft reset
// - Control bit 8 wake enable, writable both sides, reset 0
// - Data selection bits 12:9 writable both sides, reset 0
// - Scale bits 14:13 locally writable, reset 00
// - Wake status: local write 1 sets, PCI write 1 clears
// - Wake signal driven while status and enable both set
// - Wake status sets only if current state's wake flag set
// - Power data register returns selected item; its scale reads in control bits 14:13
`include "pmc_consts.vh"

module pmc_power_mgmt #(
	parameter SEL_W = 4,
	parameter DATA_W = 8
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst_b,
	// PCI configuration access (16-bit word)
	input wire cfgWrite,
	input wire cfgRead,
	input wire [8:0] cfgAddr,
	input wire [15:0] cfgWdata,
	output reg [15:0] cfgRdata,
	// Local register access (16-bit word)
	input wire locWrite,
	input wire locRead,
	input wire [8:0] locAddr,
	input wire [15:0] locWdata,
	output reg [15:0] locRdata,
	// Local loading of the power data item
	input wire locDataWrite,
	input wire [DATA_W-1:0] locDataIn,
	// Power data register view
	output wire [DATA_W-1:0] powerDataRegister,
	// Gating of PCI traffic
	input wire memIoReq,
	output wire memIoAccept,
	input wire intReq,
	output wire intOut,
	// Wake and reset
	output wire wakeOut,
	output reg softReset
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg [2:0] version;
	reg clkRequired;
	reg specialInit;
	reg state1Supported;
	reg state2Supported;
	reg [4:0] wakeStateFlags;
	reg [1:0] powerState;
	reg wakeEnable;
	reg [SEL_W-1:0] dataSelect;
	reg wakeStatus;
	wire [1:0] scaleField;

	reg [1:0] next_powerState;
	reg next_wakeStatus;
	reg next_wakeEnable;
	reg [SEL_W-1:0] next_dataSelect;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function hit;
		input [8:0] addr;
		input [8:0] ofs;
		begin
			hit = (addr == ofs);
		end
	endfunction

	wire cfgCapW = cfgWrite && hit(cfgAddr, `PMC_CFG_CAP_OFS);
	wire cfgCsrW = cfgWrite && hit(cfgAddr, `PMC_CFG_CSR_OFS);
	// The local interface is held in reset for the soft reset pulse, so
	// a local access that lands on it is dropped rather than half taken
	wire locLive = !softReset;
	wire locCapW = locLive && locWrite &&
		hit(locAddr, `PMC_LOC_CAP_OFS);
	wire locCsrW = locLive && locWrite &&
		hit(locAddr, `PMC_LOC_CSR_OFS);

	// ----------------------------------------------------------------
	// Control word fields, decoded alike for both access sides
	// ----------------------------------------------------------------
	function [1:0] stateOf;
		input [15:0] word;
		begin
			stateOf = word[`PMC_CSR_STATE_MSB:`PMC_CSR_STATE_LSB];
		end
	endfunction

	function wakeEnOf;
		input [15:0] word;
		begin
			wakeEnOf = word[`PMC_CSR_WEN_BIT];
		end
	endfunction

	// SEL_W may not exceed the four-bit field; a narrower table simply
	// aliases the upper selection values onto the lower entries
	function [SEL_W-1:0] selectOf;
		input [15:0] word;
		reg [3:0] field;
		begin
			field = word[`PMC_CSR_SEL_MSB:`PMC_CSR_SEL_LSB];
			selectOf = field[SEL_W-1:0];
		end
	endfunction

	function wakeStOf;
		input [15:0] word;
		begin
			wakeStOf = word[`PMC_CSR_WST_BIT];
		end
	endfunction

	// ----------------------------------------------------------------
	// Read data assembly
	// ----------------------------------------------------------------
	// Aux current and bit 4 are constant zero
	wire [15:0] capWord = {wakeStateFlags, state2Supported,
		state1Supported, 3'h0, specialInit, 1'b0, clkRequired,
		version};
	wire [15:0] csrWord = {wakeStatus, scaleField, dataSelect,
		wakeEnable, 6'h00, powerState};

	function [15:0] readMux;
		input [8:0] addr;
		input [8:0] capOfs;
		input [8:0] csrOfs;
		begin
			if (addr == capOfs)
				readMux = capWord;
			else if (addr == csrOfs)
				readMux = csrWord;
			else
				readMux = 16'h0000;
		end
	endfunction

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfgRdata <= 16'h0000;
			locRdata <= 16'h0000;
		end else begin
			if (cfgRead)
				cfgRdata <= readMux(cfgAddr, `PMC_CFG_CAP_OFS,
					`PMC_CFG_CSR_OFS);
			// Unmapped offsets read zero so probing neighbours is harmless
			if (softReset)
				locRdata <= 16'h0000;
			else if (locRead)
				locRdata <= readMux(locAddr, `PMC_LOC_CAP_OFS,
					`PMC_LOC_CSR_OFS);
		end
	end

	// ----------------------------------------------------------------
	// Capability word: local side only
	// ----------------------------------------------------------------
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			version <= `PMC_CAP_VER_RST;
			clkRequired <= 1'b0;
			specialInit <= 1'b0;
			state1Supported <= 1'b0;
			state2Supported <= 1'b0;
			wakeStateFlags <= 5'h00;
		end else if (locCapW) begin
			version <= locWdata[`PMC_CAP_VER_MSB:`PMC_CAP_VER_LSB];
			clkRequired <= locWdata[`PMC_CAP_CLKREQ_BIT];
			specialInit <= locWdata[`PMC_CAP_SPECINIT_BIT];
			state1Supported <= locWdata[`PMC_CAP_S1_BIT];
			state2Supported <= locWdata[`PMC_CAP_S2_BIT];
			wakeStateFlags <=
				locWdata[`PMC_CAP_WAKE_MSB:`PMC_CAP_WAKE_LSB];
		end
	end

	// ----------------------------------------------------------------
	// Power state and soft reset
	// ----------------------------------------------------------------
	// PCI write takes priority if both sides write in one cycle
	always @* begin
		next_powerState = powerState;
		// Codes for unsupported D1/D2 are still stored as written
		if (locCsrW)
			next_powerState = stateOf(locWdata);
		if (cfgCsrW)
			next_powerState = stateOf(cfgWdata);
	end

	wire leaveD3 = (powerState == `PMC_STATE_D3HOT) &&
		(next_powerState == `PMC_STATE_D0);

	// Soft reset is a one-cycle pulse; the register pair keeps its
	// contents apart from the scale bits, so the host sees the new D0 state afterwards
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			powerState <= `PMC_STATE_D0;
			softReset <= 1'b0;
		end else begin
			powerState <= next_powerState;
			softReset <= leaveD3;
		end
	end

	// ----------------------------------------------------------------
	// Wake enable and data selection
	// ----------------------------------------------------------------
	// Same priority as the power state: the PCI side wins a collision
	always @* begin
		next_wakeEnable = wakeEnable;
		next_dataSelect = dataSelect;
		if (locCsrW) begin
			next_wakeEnable = wakeEnOf(locWdata);
			next_dataSelect = selectOf(locWdata);
		end
		if (cfgCsrW) begin
			next_wakeEnable = wakeEnOf(cfgWdata);
			next_dataSelect = selectOf(cfgWdata);
		end
	end

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wakeEnable <= 1'b0;
			dataSelect <= {SEL_W{1'b0}};
		end else begin
			wakeEnable <= next_wakeEnable;
			dataSelect <= next_dataSelect;
		end
	end

	// ----------------------------------------------------------------
	// Wake status
	// ----------------------------------------------------------------
	// Only D0 to D3hot can be current here, so the D3cold flag is
	// advertised to software but never gates a set
	wire stateWakeOk = wakeStateFlags[powerState];
	wire wakeSetReq = locCsrW && wakeStOf(locWdata);
	wire wakeClrReq = cfgCsrW && wakeStOf(cfgWdata);

	// A set arriving with a clear wins so the event is not lost
	always @* begin
		next_wakeStatus = wakeStatus;
		if (wakeClrReq)
			next_wakeStatus = 1'b0;
		if (wakeSetReq && stateWakeOk)
			next_wakeStatus = 1'b1;
	end

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			wakeStatus <= 1'b0;
		else
			wakeStatus <= next_wakeStatus;
	end

	assign wakeOut = wakeStatus && wakeEnable;

	// ----------------------------------------------------------------
	// PCI traffic gating
	// ----------------------------------------------------------------
	// Combinational so a request is refused in the cycle it is made
	wire lowPower = (powerState == `PMC_STATE_D3HOT) ||
		((powerState == `PMC_STATE_D2) && state2Supported);
	assign memIoAccept = memIoReq && !lowPower;
	assign intOut = intReq && !lowPower;

	// ----------------------------------------------------------------
	// Scale and power data per selected item
	// ----------------------------------------------------------------
	// Scale follows the selection already in place before this write
	pmc_data_table #(
		.SEL_W(SEL_W),
		.DATA_W(DATA_W)
	) dataTable (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.softRst(softReset),
		.dataSelect(dataSelect),
		.scaleWrite(locCsrW),
		.scaleIn(locWdata[`PMC_CSR_SCALE_MSB:`PMC_CSR_SCALE_LSB]),
		.dataWrite(locDataWrite),
		.dataIn(locDataIn),
		.scaleOut(scaleField),
		.dataOut(powerDataRegister)
	);
endmodule

// file: src/pmc_consts.vh
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PMC_CFG_CAP_OFS 9'h042
`define PMC_CFG_CSR_OFS 9'h044
`define PMC_LOC_CAP_OFS 9'h182
`define PMC_LOC_CSR_OFS 9'h184

// ----------------------------------------------------------------
// Capability word fields
// ----------------------------------------------------------------
`define PMC_CAP_VER_LSB 0
`define PMC_CAP_VER_MSB 2
`define PMC_CAP_CLKREQ_BIT 3
`define PMC_CAP_SPECINIT_BIT 5
`define PMC_CAP_AUX_LSB 6
`define PMC_CAP_AUX_MSB 8
`define PMC_CAP_S1_BIT 9
`define PMC_CAP_S2_BIT 10
`define PMC_CAP_WAKE_LSB 11
`define PMC_CAP_WAKE_MSB 15
`define PMC_CAP_VER_RST 3'h1
`define PMC_CAP_WRMASK 16'hFE2F

// ----------------------------------------------------------------
// Control/status word fields
// ----------------------------------------------------------------
`define PMC_CSR_STATE_LSB 0
`define PMC_CSR_STATE_MSB 1
`define PMC_CSR_WEN_BIT 8
`define PMC_CSR_SEL_LSB 9
`define PMC_CSR_SEL_MSB 12
`define PMC_CSR_SCALE_LSB 13
`define PMC_CSR_SCALE_MSB 14
`define PMC_CSR_WST_BIT 15

// ----------------------------------------------------------------
// Power states
// ----------------------------------------------------------------
`define PMC_STATE_D0 2'h0
`define PMC_STATE_D1 2'h1
`define PMC_STATE_D2 2'h2
`define PMC_STATE_D3HOT 2'h3

`endif

// file: src/pmc_data_table.v
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Power data and scale table, one entry per data selection value
// ----------------------------------------------------------------
module pmc_data_table #(
	parameter SEL_W = 4,
	parameter DATA_W = 8
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst_b,
	input wire softRst,
	// Local side loading
	input wire [SEL_W-1:0] dataSelect,
	input wire scaleWrite,
	input wire [1:0] scaleIn,
	input wire dataWrite,
	input wire [DATA_W-1:0] dataIn,
	// Selected entry
	output reg [1:0] scaleOut,
	output reg [DATA_W-1:0] dataOut
);
	localparam DEPTH = 1 << SEL_W;
	reg [1:0] scaleMem [0:DEPTH-1];
	reg [DATA_W-1:0] dataMem [0:DEPTH-1];
	integer i;

	// Scale belongs to the entry chosen by the selection field
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				scaleMem[i] <= 2'h0;
				dataMem[i] <= {DATA_W{1'b0}};
			end
		end else if (softRst) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				scaleMem[i] <= 2'h0;
				dataMem[i] <= {DATA_W{1'b0}};
			end
		end else begin
			if (scaleWrite)
				scaleMem[dataSelect] <= scaleIn;
			if (dataWrite)
				dataMem[dataSelect] <= dataIn;
		end
	end

	// Outputs registered, one cycle behind a change of selection
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			scaleOut <= 2'h0;
			dataOut <= {DATA_W{1'b0}};
		end else begin
			scaleOut <= scaleMem[dataSelect];
			dataOut <= dataMem[dataSelect];
		end
	end
endmodule

// file: verification/pmc_power_mgmt_properties.sv
`timescale 1ns/1ps
module pmc_power_mgmt_chk (
	// Clock and reset
	input logic ref_clk,
	input logic rst_b,
	// Register access
	input logic cfgWrite,
	input logic cfgRead,
	input logic [8:0] cfgAddr,
	input logic [15:0] cfgWdata,
	input logic [15:0] cfgRdata,
	input logic locWrite,
	input logic [8:0] locAddr,
	input logic [15:0] locWdata,
	// Gating and wake
	input logic memIoReq,
	input logic memIoAccept,
	input logic intReq,
	input logic intOut,
	input logic wakeOut,
	input logic softReset
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	wire pciCsr = cfgWrite && cfgAddr == 9'h044;
	wire locCsr = locWrite && locAddr == 9'h184;
	mem_gate_a: assert property (memIoAccept |-> memIoReq)
		else $error("access accepted without request");
	int_gate_a: assert property (intOut |-> intReq)
		else $error("interrupt without request");
	d3_block_a: assert property (pciCsr && cfgWdata[1:0] == 2'h3
		|=> !memIoAccept && !intOut) else $error("traffic passed in D3hot");
	soft_pulse_a: assert property (softReset |=> !softReset)
		else $error("soft reset longer than one cycle");
	soft_cause_a: assert property (softReset |-> $past(pciCsr
		&& cfgWdata[1:0] == 2'h0 || locCsr && locWdata[1:0] == 2'h0))
		else $error("soft reset without write to D0");
	wake_clear_a: assert property (pciCsr
		&& (cfgWdata[15] || !cfgWdata[8]) && !(locCsr && locWdata[15])
		|=> !wakeOut) else $error("wake still driven after clear");
	cap_resv_a: assert property (cfgRead && cfgAddr == 9'h042
		|=> cfgRdata[8:6] == 3'h0 && !cfgRdata[4])
		else $error("capability reserved bits set");
	csr_resv_a: assert property (cfgRead && cfgAddr == 9'h044
		|=> cfgRdata[7:2] == 6'h0) else $error("control reserved bits set");
	unmapped_a: assert property (cfgRead
		&& !(cfgAddr inside {9'h042, 9'h044}) |=> cfgRdata == 16'h0)
		else $error("unmapped read not zero");
	cover property (softReset);
	cover property (wakeOut);
	cover property (memIoReq && !memIoAccept);
endmodule

bind pmc_power_mgmt pmc_power_mgmt_chk chkU (.ref_clk(ref_clk),
	.rst_b(rst_b), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
	.cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
	.locWrite(locWrite), .locAddr(locAddr), .locWdata(locWdata),
	.memIoReq(memIoReq), .memIoAccept(memIoAccept), .intReq(intReq),
	.intOut(intOut), .wakeOut(wakeOut), .softReset(softReset));

// file: verification/pmc_host_model.sv
`timescale 1ns/1ps
module pmc_host_model (
	// Clock and read data
	input logic ref_clk,
	input logic [15:0] cfgRdata,
	input logic [15:0] locRdata,
	// Host and local processor requests
	output logic cfgWrite,
	output logic cfgRead,
	output logic [8:0] cfgAddr,
	output logic [15:0] cfgWdata,
	output logic locWrite,
	output logic locRead,
	output logic [8:0] locAddr,
	output logic [15:0] locWdata,
	output logic locDataWrite,
	output logic [7:0] locDataIn,
	output logic memIoReq,
	output logic intReq
);
	initial begin
		{cfgWrite, cfgRead, locWrite, locRead, locDataWrite} = 5'h0;
		{cfgAddr, cfgWdata, locAddr, locWdata, locDataIn} = 58'h0;
		{memIoReq, intReq} = 2'h3;
	end
	// Leaving D3hot is only ever issued with loc=0 by callers
	task automatic acc(input bit loc, input bit rd, input logic [8:0] a,
		input logic [15:0] d, output logic [15:0] q);
		@(negedge ref_clk);
		if (loc) begin
			{locWrite, locRead, locAddr, locWdata} <= {!rd, rd, a, d};
		end else begin
			{cfgWrite, cfgRead, cfgAddr, cfgWdata} <= {!rd, rd, a, d};
		end
		@(negedge ref_clk);
		{cfgWrite, cfgRead, locWrite, locRead} <= 4'h0;
		// Released lines scramble so stale values are never trusted
		{cfgAddr, cfgWdata} <= ~{cfgAddr, cfgWdata};
		{locAddr, locWdata} <= ~{locAddr, locWdata};
		@(negedge ref_clk);
		q = loc ? locRdata : cfgRdata;
	endtask
	// Callers set the selection before loading each item
	task automatic dat(input logic [7:0] v);
		@(negedge ref_clk);
		{locDataWrite, locDataIn} <= {1'h1, v};
		@(negedge ref_clk);
		{locDataWrite, locDataIn} <= {1'h0, ~v};
	endtask
	// Traffic requests change off the edge and settle for one cycle
	task automatic req(input logic [1:0] v);
		@(negedge ref_clk);
		{memIoReq, intReq} <= v;
		@(negedge ref_clk);
	endtask
endmodule

// file: verification/pmc_power_mgmt_tb.sv
`timescale 1ns/1ps
module pmc_power_mgmt_tb;
	logic ref_clk = 1'h0;
	logic rst_b = 1'h0;
	logic cfgWrite, cfgRead, locWrite, locRead, locDataWrite;
	logic memIoReq, memIoAccept, intReq, intOut, wakeOut, softReset;
	logic [8:0] cfgAddr, locAddr;
	logic [15:0] cfgWdata, cfgRdata, locWdata, locRdata, q;
	logic [7:0] locDataIn, powerDataRegister;
	int nFail = 0;
	int checkCount = 0;
	int nRst = 0;
	pmc_power_mgmt dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
		.cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
		.cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .locWrite(locWrite),
		.locRead(locRead), .locAddr(locAddr), .locWdata(locWdata),
		.locRdata(locRdata), .locDataWrite(locDataWrite),
		.locDataIn(locDataIn), .powerDataRegister(powerDataRegister),
		.memIoReq(memIoReq), .memIoAccept(memIoAccept), .intReq(intReq),
		.intOut(intOut), .wakeOut(wakeOut), .softReset(softReset));
	pmc_host_model hostU (.ref_clk(ref_clk), .cfgRdata(cfgRdata),
		.locRdata(locRdata), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
		.cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .locWrite(locWrite),
		.locRead(locRead), .locAddr(locAddr), .locWdata(locWdata),
		.locDataWrite(locDataWrite), .locDataIn(locDataIn),
		.memIoReq(memIoReq), .intReq(intReq));
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (softReset === 1'h1) nRst++;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checkCount++;
		if (seen !== exp) begin
			nFail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic w(input bit l, input logic [8:0] a, input logic [15:0] d);
		hostU.acc(l, 1'h0, a, d, q);
	endtask
	task automatic r(input bit l, input logic [8:0] a);
		hostU.acc(l, 1'h1, a, 16'h0, q);
	endtask
	task automatic stopTest();
		$display("Checks %0d, mismatches %0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(negedge ref_clk);
		rst_b = 1'h1;
		r(0, 9'h042);
		chk(q, 16'h0001);
		r(1, 9'h184);
		chk(q, 16'h0000);
		chk({14'h0, memIoAccept, intOut}, 16'h0003);
		hostU.req(2'h1);
		chk({14'h0, memIoAccept, intOut}, 16'h0001);
		hostU.req(2'h2);
		chk({14'h0, memIoAccept, intOut}, 16'h0002);
		hostU.req(2'h3);
		w(1, 9'h182, 16'hFFFF);
		r(0, 9'h042);
		chk(q, 16'hFE2F);
		w(0, 9'h042, 16'h0000);
		r(1, 9'h182);
		chk(q, 16'hFE2F);
		r(0, 9'h046);
		chk(q, 16'h0000);
		w(0, 9'h044, 16'hFFFF);
		r(0, 9'h044);
		chk(q, 16'h1F03);
		chk({14'h0, memIoAccept, intOut}, 16'h0000);
		w(0, 9'h044, 16'h0000);
		chk(16'(nRst), 16'h0001);
		// Selection is set first, then the scale for that item
		w(1, 9'h184, 16'h0400);
		w(1, 9'h184, 16'h2400);
		hostU.dat(8'h5A);
		w(1, 9'h184, 16'h2600);
		w(1, 9'h184, 16'h4600);
		hostU.dat(8'h3C);
		w(0, 9'h044, 16'h0600);
		r(1, 9'h184);
		chk(q, 16'h4600);
		chk({8'h0, powerDataRegister}, 16'h003C);
		w(0, 9'h044, 16'h0400);
		r(1, 9'h184);
		chk(q, 16'h2400);
		chk({8'h0, powerDataRegister}, 16'h005A);
		w(0, 9'h044, 16'h0100);
		w(1, 9'h184, 16'h8100);
		chk({15'h0, wakeOut}, 16'h0001);
		r(0, 9'h044);
		chk(q, 16'h8100);
		w(0, 9'h044, 16'h8100);
		chk({15'h0, wakeOut}, 16'h0000);
		w(1, 9'h182, 16'h0001);
		w(1, 9'h184, 16'h8100);
		r(0, 9'h044);
		chk(q, 16'h0100);
		w(1, 9'h182, 16'h0801);
		w(1, 9'h184, 16'h8000);
		chk({15'h0, wakeOut}, 16'h0000);
		w(0, 9'h044, 16'h0100);
		chk({15'h0, wakeOut}, 16'h0001);
		w(0, 9'h044, 16'h0002);
		chk({14'h0, memIoAccept, intOut}, 16'h0003);
		w(1, 9'h182, 16'h0C01);
		chk({14'h0, memIoAccept, intOut}, 16'h0000);
		chk(16'(nRst), 16'h0001);
		stopTest();
	end
	initial begin
		#1ms;
		nFail++;
		stopTest();
	end
endmodule
